// ===== bench/bsp_link_asserts.sv
`timescale 1ns/1ps
// Pin-level watch on the link, sampled on rises of k
module bsp_link_asserts (
   input wire logic k,                   // Main link clock
   input wire logic k_n,                 // Complementary link clock
   input wire logic rst_n,               // Async reset, active low
   input wire logic read_port_select_n,  // Read command
   input wire logic write_port_select_n, // Write command
   input wire logic q_oe_n,              // Low while q is driven
   input wire logic output_valid_flag,   // Read data valid
   input wire logic echo_strobe_out,     // Echo of k
   input wire logic echo_strobe_out_n    // Echo of k_n
);
   default clocking cb @(posedge k); endclocking
   default disable iff (!rst_n);

   ////////////////////////////////////////////////////////////////////////////////
   // Read command taken on this rise
   sequence s_rd_cmd;
      !read_port_select_n;
   endsequence
   // Valid over both rises that close a burst (beats w0 and w2)
   sequence s_rd_beats;
      output_valid_flag [*2];
   endsequence

   ////////////////////////////////////////////////////////////////////////////////
   // First beat half a cycle before the 3rd rise, last on the 4th
   a_rd_latency: assert property (s_rd_cmd |-> ##3 s_rd_beats)
      else $error("read valid window misplaced");
   // Valid only ever answers a read three or four rises back
   a_valid_cause: assert property (output_valid_flag |->
      $past(read_port_select_n, 3) == 1'b0 || $past(read_port_select_n, 4) == 1'b0)
      else $error("valid without a read behind it");
   // Burst done and port deselected, so the outputs float
   a_idle_float: assert property (read_port_select_n [*4] |=> q_oe_n)
      else $error("read outputs still driven after deselect");
   // Drivers on exactly while data is valid
   a_oe_valid: assert property (q_oe_n == !output_valid_flag)
      else $error("output enable and valid disagree");
   // Echo pair follows the input pair
   a_echo_k: assert property (echo_strobe_out == k && echo_strobe_out_n == k_n)
      else $error("echo strobes not following k");
   // Reads at least two k cycles apart
   a_rd_spacing: assert property (s_rd_cmd |=> read_port_select_n)
      else $error("reads on adjacent k rises");
   // Write bursts must not overlap their beats
   a_wr_spacing: assert property (!write_port_select_n |=> write_port_select_n)
      else $error("writes on adjacent k rises");
   // Shared address bus: one port per rise
   a_one_port: assert property (read_port_select_n || write_port_select_n)
      else $error("read and write on the same k rise");
endmodule // bsp_link_asserts

// ===== bench/tb_burst_sram_port_pins.sv
`timescale 1ns/1ps
// Drives the controller user side, models the array, checks readback
module tb_burst_sram_port_pins;
   localparam int DW = 36;                  // Widest organisation
   localparam int AW = 17;                  // Its address width
   logic              clock;                // 20 MHz system clock
   logic              rst_n;                // Async reset, active low
   logic              rd_req;               // User read request
   logic              wr_req;               // User write request
   logic              rd_ready;             // Read slot open
   logic              wr_ready;             // Write slot open
   logic              rd_valid;             // Read burst returned
   logic [AW-1:0]     rd_addr;              // Read burst address
   logic [AW-1:0]     wr_addr;              // Write burst address
   logic [4*DW-1:0]   rd_data;              // Four words, word 0 low
   logic [4*DW-1:0]   wr_data;              // Four words, word 0 low
   logic [15:0]       wr_mask_n;            // Lane masks, beat 0 low
   logic [DW-1:0]     mem [int];            // Expected array, word keyed
   logic [AW-1:0]     aq [$];               // Addresses in use
   int                fail_count;           // Mismatches seen
   int                num_checks;           // Comparisons made

   bsp_link_if #(.DATA_W(DW), .ADDR_W(AW)) bsp_link_if_inst ();
   bsp_sram_ctl #(.DATA_W(DW), .ADDR_W(AW)) bsp_sram_ctl_inst (.clock(clock), .rst_n(rst_n),
      .rd_req(rd_req), .rd_addr(rd_addr), .rd_ready(rd_ready), .rd_data(rd_data),
      .rd_valid(rd_valid), .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data),
      .wr_mask_n(wr_mask_n), .wr_ready(wr_ready), .link(bsp_link_if_inst.ctl));
   bsp_sram_dev #(.DATA_W(DW), .ADDR_W(AW)) bsp_sram_dev_inst (.link(bsp_link_if_inst.dev),
      .rst_n(rst_n));
   bsp_link_asserts bsp_link_asserts_inst (.k(bsp_link_if_inst.k), .k_n(bsp_link_if_inst.k_n),
      .rst_n(rst_n), .read_port_select_n(bsp_link_if_inst.read_port_select_n),
      .write_port_select_n(bsp_link_if_inst.write_port_select_n),
      .q_oe_n(bsp_link_if_inst.q_oe_n), .output_valid_flag(bsp_link_if_inst.output_valid_flag),
      .echo_strobe_out(bsp_link_if_inst.echo_strobe_out),
      .echo_strobe_out_n(bsp_link_if_inst.echo_strobe_out_n));

   ////////////////////////////////////////////////////////////////////////////////
   // Free-running system clock
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   // Compare and count
   task automatic check(input logic [4*DW-1:0] seen, input logic [4*DW-1:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Verdict and end of run
   task automatic test_done();
      $display("Checks %0d, mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Ready is combinational, so judge it late in the low half of clock
   task automatic wait_take(input bit is_rd);
      bit got;
      got = 1'b0;
      for (int n = 0; n < 40 && !got; n++) begin
         #24;
         got = is_rd ? (rd_ready === 1'b1) : (wr_ready === 1'b1);
         @(negedge clock);
      end
      if (!got) begin
         fail_count++;
         test_done();
      end
   endtask
   // Expected burst from the model, word 0 low
   function automatic logic [4*DW-1:0] exp_burst(input logic [AW-1:0] a);
      logic [4*DW-1:0] e;
      for (int w = 0; w < 4; w++) e[w*DW +: DW] = mem[int'(a) * 4 + w];
      return e;
   endfunction
   // Random four-word burst
   function automatic logic [4*DW-1:0] rnd_burst();
      logic [4*DW-1:0] r;
      for (int w = 0; w < 4; w++) r[w*DW +: DW] = DW'({$urandom, $urandom});
      return r;
   endfunction
   // Posted write; only lanes with mask low reach the model
   task automatic do_write(input logic [AW-1:0] a, input logic [4*DW-1:0] d,
                           input logic [15:0] m);
      wr_addr = a;
      wr_data = d;
      wr_mask_n = m;
      wr_req = 1'b1;
      wait_take(1'b0);
      wr_req = 1'b0;
      // Let an edge pass so a following call never re-raises it at once
      @(negedge clock);
      for (int i = 0; i < 16; i++) begin
         if (!m[i]) mem[int'(a) * 4 + i / 4][(i % 4) * 9 +: 9] = d[i*9 +: 9];
      end
   endtask
   // Read a burst, check latency and words
   task automatic do_read(input logic [AW-1:0] a);
      logic [4*DW-1:0] e;
      int              lat;
      e = exp_burst(a);
      rd_addr = a;
      rd_req = 1'b1;
      wait_take(1'b1);
      rd_req = 1'b0;
      for (lat = 1; lat < 20; lat++) begin
         @(posedge clock);
         #1;
         if (rd_valid === 1'b1) break;
      end
      check(144'(lat), 144'(11));
      check(rd_data, e);
      @(negedge clock);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      rst_n = 1'b0;
      rd_req = 1'b0;
      wr_req = 1'b0;
      rd_addr = '0;
      wr_addr = '0;
      wr_data = '0;
      wr_mask_n = '1;
      fail_count = 0;
      num_checks = 0;
      void'($urandom(32'h22980bad));
      repeat (16) @(negedge clock);
      rst_n = 1'b1;
      // Full bursts at both address ends and at random places
      for (int i = 0; i < 6; i++) begin
         aq.push_back(i == 0 ? '0 : i == 1 ? '1 : AW'($urandom));
         do_write(aq[i], rnd_burst(), 16'h0000);
      end
      repeat (8) @(negedge clock);
      foreach (aq[i]) do_read(aq[i]);
      $display("Test full bursts done");
      // Lane masks, first write fully masked
      for (int j = 0; j < 12; j++) begin
         do_write(aq[j % 6], rnd_burst(), j == 0 ? 16'hffff : 16'($urandom));
      end
      repeat (8) @(negedge clock);
      foreach (aq[i]) do_read(aq[i]);
      $display("Test lane masks done");
      // Read and write asked in the same cycle
      for (int j = 0; j < 3; j++) begin
         fork
            do_write(aq[j] ^ 17'h00001, rnd_burst(), 16'h0000);
            do_read(aq[j + 3]);
         join
      end
      repeat (8) @(negedge clock);
      for (int j = 0; j < 3; j++) do_read(aq[j] ^ 17'h00001);
      $display("Test contending ports done");
      // Reset in mid-run: outputs floated and invalid
      rst_n = 1'b0;
      repeat (2) @(negedge clock);
      check(144'({bsp_link_if_inst.q_oe_n, bsp_link_if_inst.output_valid_flag}),
            144'(2'h2));
      rst_n = 1'b1;
      do_write(aq[2], rnd_burst(), 16'h0000);
      repeat (8) @(negedge clock);
      do_read(aq[2]);
      $display("Test reset recovery done");
      test_done();
   end
endmodule // tb_burst_sram_port_pins

// ===== rtl/bsp_link_if.sv
`timescale 1ns/1ps
// Pins between the memory controller and the burst memory
interface bsp_link_if #(
   parameter int DATA_W = bsp_pkg::DATA_W_DEF,
   parameter int ADDR_W = bsp_pkg::ADDR_W_DEF
);
   localparam int LANES = DATA_W / bsp_pkg::LANE_W;

   logic              k;                      // Main input clock
   logic              k_n;                    // Complementary input clock
   logic [ADDR_W-1:0] addr;                   // Shared read/write address
   logic              read_port_select_n;     // Starts a read burst
   logic              write_port_select_n;    // Starts a write burst
   logic [DATA_W-1:0] d;                      // Write data beats
   logic [LANES-1:0]  byte_lane_write_mask_n; // Per-lane write mask
   logic [DATA_W-1:0] q;                      // Read data beats
   logic              q_oe_n;                 // Low while q is driven
   logic              output_valid_flag;      // Read data valid
   logic              echo_strobe_out;        // Echo of k
   logic              echo_strobe_out_n;      // Echo of k_n

   modport dev (
      input  k, k_n, addr, read_port_select_n, write_port_select_n, d,
             byte_lane_write_mask_n,
      output q, q_oe_n, output_valid_flag, echo_strobe_out, echo_strobe_out_n
   );
   modport ctl (
      output k, k_n, addr, read_port_select_n, write_port_select_n, d,
             byte_lane_write_mask_n,
      input  q, q_oe_n, output_valid_flag, echo_strobe_out, echo_strobe_out_n
   );
endinterface

// ===== rtl/bsp_pkg.sv
package bsp_pkg;
   // Organisation: lanes of nine bits, four words per burst
   localparam int LANE_W     = 9;
   localparam int BURST_LEN  = 4;
   localparam int BEAT_W     = 2;             // Index of a word inside a burst
   localparam int DATA_W_DEF = 36;            // Widest organisation
   localparam int ADDR_W_X9  = 19;            // Address width, 9-bit words
   localparam int ADDR_W_X18 = 18;            // Address width, 18-bit words
   localparam int ADDR_W_X36 = 17;            // Address width, 36-bit words
   localparam int ADDR_W_DEF = ADDR_W_X36;
   // Read pipeline depth in link cycles: first beat at 2.5, last at 4
   localparam int RD_STAGES  = 4;
   // Write pipeline depth in link cycles: last beat caught at 2.5
   localparam int WR_STAGES  = 3;
   // Controller write sequencer steps (clock cycles after issue)
   localparam logic [2:0] WR_STEP_IDLE  = 3'h0;
   localparam logic [2:0] WR_STEP_FIRST = 3'h2;
   localparam logic [2:0] WR_STEP_LAST  = 3'h5;
   // Read data passes this many flops in the controller
   localparam int SYNC_STAGES = 2;

   // Address width that an organisation needs
   function automatic int addr_w_for(input int dw);
      if (dw == LANE_W) return ADDR_W_X9;
      else if (dw == 2 * LANE_W) return ADDR_W_X18;
      else if (dw == 4 * LANE_W) return ADDR_W_X36;
      else return 0;
   endfunction
endpackage

// ===== rtl/bsp_sram_ctl.sv
`timescale 1ns/1ps
// Controller end: makes k from clock, issues bursts, gathers reads
module bsp_sram_ctl #(
   parameter int DATA_W = bsp_pkg::DATA_W_DEF,
   parameter int ADDR_W = bsp_pkg::ADDR_W_DEF
) (
   input  wire logic                  clock,
   input  wire logic                  rst_n,
   input  wire logic                  rd_req,
   input  wire logic [ADDR_W-1:0]     rd_addr,
   output logic                       rd_ready,
   output logic [4*DATA_W-1:0]        rd_data,
   output logic                       rd_valid,
   input  wire logic                  wr_req,
   input  wire logic [ADDR_W-1:0]     wr_addr,
   input  wire logic [4*DATA_W-1:0]   wr_data,
   input  wire logic [4*DATA_W/9-1:0] wr_mask_n,
   output logic                       wr_ready,
   bsp_link_if.ctl                    link
);
   localparam int LANES = DATA_W / bsp_pkg::LANE_W;

   if (ADDR_W != bsp_pkg::addr_w_for(DATA_W)) begin : g_bad_org
      $error("Unsupported data or address width");
   end

   ////////////////////////////////////////////////////////////////////////
   // Link clock: divide by two on the falling edge, so every pin set on
   // the rising edge is settled half a cycle before k or k_n rise
   ////////////////////////////////////////////////////////////////////////
   logic k_ff;                                // Link clock level
   logic nxt_k;

   always_comb nxt_k = ~k_ff;

   always_ff @(negedge clock or negedge rst_n) begin
      if (!rst_n) k_ff <= 1'b0;
      else        k_ff <= nxt_k;
   end

   assign link.k   = k_ff;
   assign link.k_n = ~k_ff;

   ////////////////////////////////////////////////////////////////////////
   // Command issue: reads and writes on alternate k rises
   ////////////////////////////////////////////////////////////////////////
   logic              slot_ff;                // High: write slot is next
   logic [ADDR_W-1:0] addr_ff;
   logic              rps_n_ff;
   logic              wps_n_ff;
   logic [2:0]        wstep_ff;               // Write data sequencer
   logic [4*DATA_W-1:0] wbuf_ff;              // Burst being written
   logic [4*LANES-1:0]  wmsk_ff;
   logic [DATA_W-1:0] d_ff;
   logic [LANES-1:0]  m_ff;
   logic              slot_ff_n;
   logic              nxt_slot;
   logic [ADDR_W-1:0] nxt_addr;
   logic              nxt_rps_n;
   logic              nxt_wps_n;
   logic [2:0]        nxt_wstep;
   logic [4*DATA_W-1:0] nxt_wbuf;
   logic [4*LANES-1:0]  nxt_wmsk;
   logic [DATA_W-1:0] nxt_d;
   logic [LANES-1:0]  nxt_m;
   logic [1:0]        beat;

   // Commands only where k is low, i.e. the next k edge is a rise
   assign slot_ff_n = ~slot_ff;
   assign rd_ready  = ~k_ff & slot_ff_n;
   // One write in flight; halves write rate but needs a single buffer
   assign wr_ready  = ~k_ff & slot_ff & (wstep_ff == bsp_pkg::WR_STEP_IDLE);

   always_comb begin
      nxt_slot  = k_ff ? slot_ff : ~slot_ff;
      nxt_addr  = addr_ff;
      nxt_rps_n = 1'b1;
      nxt_wps_n = 1'b1;
      nxt_wbuf  = wbuf_ff;
      nxt_wmsk  = wmsk_ff;
      nxt_d     = d_ff;
      nxt_m     = m_ff;
      beat      = 2'(wstep_ff - bsp_pkg::WR_STEP_FIRST);
      nxt_wstep = (wstep_ff == bsp_pkg::WR_STEP_IDLE || wstep_ff == bsp_pkg::WR_STEP_LAST)
                  ? bsp_pkg::WR_STEP_IDLE : 3'(wstep_ff + 3'h1);
      if (rd_req && rd_ready) begin
         nxt_rps_n = 1'b0;
         nxt_addr  = rd_addr;
      end else if (wr_req && wr_ready) begin
         nxt_wps_n = 1'b0;
         nxt_addr  = wr_addr;
         nxt_wbuf  = wr_data;
         nxt_wmsk  = wr_mask_n;
         nxt_wstep = 3'h1;
      end
      // Beat and its mask leave together, half a clock ahead of its edge
      if (wstep_ff >= bsp_pkg::WR_STEP_FIRST) begin
         nxt_d = wbuf_ff[beat*DATA_W +: DATA_W];
         nxt_m = wmsk_ff[beat*LANES +: LANES];
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         slot_ff  <= 1'b0;
         addr_ff  <= '0;
         rps_n_ff <= 1'b1;
         wps_n_ff <= 1'b1;
         wstep_ff <= bsp_pkg::WR_STEP_IDLE;
         wbuf_ff  <= '0;
         wmsk_ff  <= '1;
         d_ff     <= '0;
         m_ff     <= '1;
      end else begin
         slot_ff  <= nxt_slot;
         addr_ff  <= nxt_addr;
         rps_n_ff <= nxt_rps_n;
         wps_n_ff <= nxt_wps_n;
         wstep_ff <= nxt_wstep;
         wbuf_ff  <= nxt_wbuf;
         wmsk_ff  <= nxt_wmsk;
         d_ff     <= nxt_d;
         m_ff     <= nxt_m;
      end
   end

   assign link.addr                   = addr_ff;
   assign link.read_port_select_n     = rps_n_ff;
   assign link.write_port_select_n    = wps_n_ff;
   assign link.d                      = d_ff;
   assign link.byte_lane_write_mask_n = m_ff;

   ////////////////////////////////////////////////////////////////////////
   // Read capture: pins pass two flops, then beats are counted by valid
   ////////////////////////////////////////////////////////////////////////
   logic [DATA_W-1:0]   q_s1_ff, q_s2_ff;     // Data synchroniser
   logic                v_s1_ff, v_s2_ff;     // Valid synchroniser
   logic [1:0]          rcnt_ff;              // Beats gathered so far
   logic [4*DATA_W-1:0] rx_ff;
   logic [4*DATA_W-1:0] rd_data_ff;
   logic                rd_valid_ff;
   logic [1:0]          nxt_rcnt;
   logic [4*DATA_W-1:0] nxt_rx;
   logic [4*DATA_W-1:0] nxt_rd_data;
   logic                nxt_rd_valid;

   always_comb begin
      nxt_rcnt     = rcnt_ff;
      nxt_rx       = rx_ff;
      nxt_rd_data  = rd_data_ff;
      nxt_rd_valid = 1'b0;
      if (v_s2_ff) begin
         nxt_rx[rcnt_ff*DATA_W +: DATA_W] = q_s2_ff;
         nxt_rcnt = 2'(rcnt_ff + 2'h1);
         if (rcnt_ff == 2'h3) begin
            nxt_rd_data = {q_s2_ff, rx_ff[3*DATA_W-1:0]};
            nxt_rd_valid = 1'b1;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         q_s1_ff     <= '0;
         q_s2_ff     <= '0;
         v_s1_ff     <= 1'b0;
         v_s2_ff     <= 1'b0;
         rcnt_ff     <= 2'h0;
         rx_ff       <= '0;
         rd_data_ff  <= '0;
         rd_valid_ff <= 1'b0;
      end else begin
         q_s1_ff     <= link.q;
         q_s2_ff     <= q_s1_ff;
         v_s1_ff     <= link.output_valid_flag;
         v_s2_ff     <= v_s1_ff;
         rcnt_ff     <= nxt_rcnt;
         rx_ff       <= nxt_rx;
         rd_data_ff  <= nxt_rd_data;
         rd_valid_ff <= nxt_rd_valid;
      end
   end

   assign rd_data  = rd_data_ff;
   assign rd_valid = rd_valid_ff;
endmodule // bsp_sram_ctl

// ===== rtl/bsp_sram_dev.sv
`timescale 1ns/1ps
module bsp_sram_dev #(
   parameter int DATA_W = bsp_pkg::DATA_W_DEF,
   parameter int ADDR_W = bsp_pkg::ADDR_W_DEF
) (
   bsp_link_if.dev    link,
   input  wire logic  rst_n
);
   localparam int LANES = DATA_W / bsp_pkg::LANE_W;
   localparam int IDX_W = ADDR_W + bsp_pkg::BEAT_W;
   localparam int DEPTH = 1 << IDX_W;

   // Only the byte-masked organisations are served
   if (ADDR_W != bsp_pkg::addr_w_for(DATA_W)) begin : g_bad_org
      $error("Unsupported data or address width");
   end

   ////////////////////////////////////////////////////////////////////////
   // Array: four sub-arrays interleaved by the low two index bits
   ////////////////////////////////////////////////////////////////////////
   logic [DATA_W-1:0] mem [DEPTH];

   // Keep lanes whose mask is high, take the rest from new data
   function automatic logic [DATA_W-1:0] merge(
      input logic [DATA_W-1:0] old_w,
      input logic [DATA_W-1:0] new_w,
      input logic [LANES-1:0]  mask_n
   );
      logic [DATA_W-1:0] res;
      res = old_w;
      for (int b = 0; b < DATA_W; b++) begin
         // Lane n covers bits 9n+8 down to 9n
         res[b] = mask_n[b / bsp_pkg::LANE_W] ? old_w[b] : new_w[b];
      end
      return res;
   endfunction

   // Word index from burst address and beat number
   function automatic logic [IDX_W-1:0] idx(
      input logic [ADDR_W-1:0]          a,
      input logic [bsp_pkg::BEAT_W-1:0] beat
   );
      return {a, beat};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // k_n domain: second and fourth write beats, first and third read beats
   ////////////////////////////////////////////////////////////////////////
   logic [DATA_W-1:0] fall_d_ff;              // Write data caught on k_n
   logic [LANES-1:0]  fall_m_ff;              // Lane masks caught with it
   logic [DATA_W-1:0] fall_q_ff;              // Read beat launched on k_n
   logic              fall_vld_ff;            // That beat is valid
   logic [DATA_W-1:0] nxt_fall_d;
   logic [LANES-1:0]  nxt_fall_m;
   logic [DATA_W-1:0] nxt_fall_q;
   logic              nxt_fall_vld;

   // Select words chosen in the k domain half a cycle before
   logic [IDX_W-1:0]  fall_idx_ff;            // Word for next k_n beat
   logic              fall_en_ff;             // A read beat is due on k_n

   // Data and mask are always caught together; the k domain decides use
   always_comb begin
      nxt_fall_d   = link.d;
      nxt_fall_m   = link.byte_lane_write_mask_n;
      nxt_fall_q   = fall_en_ff ? mem[fall_idx_ff] : fall_q_ff;
      nxt_fall_vld = fall_en_ff;
   end

   // k and k_n are one complementary pair, so k-domain selects are
   // half a cycle old and settled here; no synchroniser is wanted
   always_ff @(posedge link.k_n or negedge rst_n) begin
      if (!rst_n) begin
         fall_d_ff   <= '0;
         fall_m_ff   <= '1;
         fall_q_ff   <= '0;
         fall_vld_ff <= 1'b0;
      end else begin
         fall_d_ff   <= nxt_fall_d;
         fall_m_ff   <= nxt_fall_m;
         fall_q_ff   <= nxt_fall_q;
         fall_vld_ff <= nxt_fall_vld;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // k domain: command capture and read pipeline
   ////////////////////////////////////////////////////////////////////////
   logic [bsp_pkg::RD_STAGES:1] rd_vld_ff;    // Read burst age in cycles
   logic [ADDR_W-1:0]  rd_adr_ff [bsp_pkg::RD_STAGES:1];
   logic [DATA_W-1:0]  rise_q_ff;             // Read beat launched on k
   logic               rise_vld_ff;           // That beat is valid
   logic [bsp_pkg::RD_STAGES:1] nxt_rd_vld;
   logic [ADDR_W-1:0]  nxt_rd_adr [bsp_pkg::RD_STAGES:1];
   logic [DATA_W-1:0]  nxt_rise_q;
   logic               nxt_rise_vld;
   logic [IDX_W-1:0]   nxt_fall_idx;
   logic               nxt_fall_en;

   // Burst timing: command T0, beats at T2.5, T3, T3.5, T4.
   // Bursts closer than two cycles would collide on the outputs; the
   // alternate-edge command scheme never produces that.
   always_comb begin
      // Sample read select on every k rise
      nxt_rd_vld    = {rd_vld_ff[bsp_pkg::RD_STAGES-1:1],
                       ~link.read_port_select_n};
      // Latch address only for a selected read
      nxt_rd_adr[1] = link.read_port_select_n ? rd_adr_ff[1] : link.addr;
      for (int s = 2; s <= bsp_pkg::RD_STAGES; s++) begin
         nxt_rd_adr[s] = rd_adr_ff[s-1];
      end
      // Rise beats: word 1 leaving stage 3, word 3 leaving stage 4
      if (rd_vld_ff[3]) begin
         nxt_rise_q   = mem[idx(rd_adr_ff[3], 2'h1)];
         nxt_rise_vld = 1'b1;
      end else if (rd_vld_ff[4]) begin
         nxt_rise_q   = mem[idx(rd_adr_ff[4], 2'h3)];
         nxt_rise_vld = 1'b1;
      end else begin
         // Burst done: valid drops, outputs float after this edge
         nxt_rise_q   = rise_q_ff;
         nxt_rise_vld = 1'b0;
      end
      // Fall beats: word 0 for stage 2 (T2.5), word 2 for stage 3
      if (rd_vld_ff[2]) begin
         nxt_fall_idx = idx(rd_adr_ff[2], 2'h0);
         nxt_fall_en  = 1'b1;
      end else if (rd_vld_ff[3]) begin
         nxt_fall_idx = idx(rd_adr_ff[3], 2'h2);
         nxt_fall_en  = 1'b1;
      end else begin
         nxt_fall_idx = fall_idx_ff;
         nxt_fall_en  = 1'b0;
      end
   end

   // Register read pipeline
   always_ff @(posedge link.k or negedge rst_n) begin
      if (!rst_n) begin
         rd_vld_ff   <= '0;
         rd_adr_ff   <= '{default: '0};
         rise_q_ff   <= '0;
         rise_vld_ff <= 1'b0;
         fall_idx_ff <= '0;
         fall_en_ff  <= 1'b0;
      end else begin
         rd_vld_ff   <= nxt_rd_vld;
         rd_adr_ff   <= nxt_rd_adr;
         rise_q_ff   <= nxt_rise_q;
         rise_vld_ff <= nxt_rise_vld;
         fall_idx_ff <= nxt_fall_idx;
         fall_en_ff  <= nxt_fall_en;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // k domain: write pipeline
   ////////////////////////////////////////////////////////////////////////
   logic [bsp_pkg::WR_STAGES:1] wr_vld_ff;    // Write burst age in cycles
   logic [ADDR_W-1:0]  wr_adr_ff [bsp_pkg::WR_STAGES:1];
   logic [bsp_pkg::WR_STAGES:1] nxt_wr_vld;
   logic [ADDR_W-1:0]  nxt_wr_adr [bsp_pkg::WR_STAGES:1];

   // Data beats follow at T1, T1.5, T2, T2.5; deselect ignores data
   always_comb begin
      nxt_wr_vld    = {wr_vld_ff[bsp_pkg::WR_STAGES-1:1],
                       ~link.write_port_select_n};
      nxt_wr_adr[1] = link.write_port_select_n ? wr_adr_ff[1] : link.addr;
      for (int s = 2; s <= bsp_pkg::WR_STAGES; s++) begin
         nxt_wr_adr[s] = wr_adr_ff[s-1];
      end
   end

   // Register write pipeline
   always_ff @(posedge link.k or negedge rst_n) begin
      if (!rst_n) begin
         wr_vld_ff <= '0;
         wr_adr_ff <= '{default: '0};
      end else begin
         wr_vld_ff <= nxt_wr_vld;
         wr_adr_ff <= nxt_wr_adr;
      end
   end

   // Array update; k_n beats land on the next k rise. Not reset,
   // since a memory holds no defined contents at power up.
   always_ff @(posedge link.k) begin
      if (wr_vld_ff[1]) begin
         // Beat 0 with mask taken on this same edge
         mem[idx(wr_adr_ff[1], 2'h0)] <= merge(mem[idx(wr_adr_ff[1], 2'h0)],
            link.d, link.byte_lane_write_mask_n);
      end
      if (wr_vld_ff[2]) begin
         mem[idx(wr_adr_ff[2], 2'h1)] <= merge(mem[idx(wr_adr_ff[2], 2'h1)],
            fall_d_ff, fall_m_ff);
         mem[idx(wr_adr_ff[2], 2'h2)] <= merge(mem[idx(wr_adr_ff[2], 2'h2)],
            link.d, link.byte_lane_write_mask_n);
      end
      if (wr_vld_ff[3]) begin
         mem[idx(wr_adr_ff[3], 2'h3)] <= merge(mem[idx(wr_adr_ff[3], 2'h3)],
            fall_d_ff, fall_m_ff);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pins
   ////////////////////////////////////////////////////////////////////////
   logic out_vld;                             // Beat valid in this half

   // High half shows the k beat, low half the k_n beat
   assign out_vld                = link.k ? rise_vld_ff : fall_vld_ff;
   assign link.q                 = link.k ? rise_q_ff : fall_q_ff;
   // Float whenever no beat is valid
   assign link.q_oe_n            = ~out_vld;
   // Flag switches on the same edges that move the echoes
   assign link.output_valid_flag = out_vld;
   // Echoes run freely with the input clocks
   assign link.echo_strobe_out   = link.k;
   assign link.echo_strobe_out_n = link.k_n;
endmodule // bsp_sram_dev
